// ### cgic_ctrl.sv
// shared socket interrupt control register and its effects
// Function
// - one control register governs both sockets
// - bits 7..5 read zero, writes ignored
// - bit 4 picks edge or level host irq for second card
// - bit 3 picks edge or level host irq for first card
// - bit 2 picks clear-on-read or write-one-to-clear for status flags
// - bit 1 picks edge or level host irq for status changes
// - bit 0 floats card outputs until a card cycle runs
// - after each card cycle outputs float again in sleep mode
// - interrupts still accepted in sleep; only card access wakes
// - bits 2..0 cleared only by global reset, not bus reset
// - write-one clear of card-detect flag also clears soft trigger
`timescale 1ns/1ps
`default_nettype none
module cgic_ctrl (
	input wire logic mclk,
	input wire logic rst,
	input wire logic global_reset_in,
	input wire logic bus_reset_in,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_wdata,
	output logic [7:0] reg_rdata,
	input wire logic [1:0] card_irq_in,
	input wire logic status_irq_in,
	input wire logic card_cycle_active,
	input wire logic cd_flag_write_one,
	output logic status_clear_on_read,
	output logic soft_card_detect_clear,
	output logic card_outputs_float,
	output logic [2:0] host_irq
);
	logic [1:0] card_mode_reg;
	logic [2:0] gr_reg;
	logic [7:0] rdata_reg;
	logic [2:0] src_s1, src_s2, src_s3, src_last;
	logic [2:0] irq_reg, irq_next;
	logic float_reg, swclr_reg, cor_reg;
	wire logic hit;
	wire logic wr_hit;
	wire logic [7:0] ctrl_view;
	wire logic [2:0] level_sel;
	wire logic [2:0] src_seen;
	wire logic [2:0] src_rise;
	wire logic global_reset_in_q;
	wire logic bus_reset_in_q;

	// one address for both sockets
	// single shared copy
	assign hit = (reg_addr == cgic_pkg::GLOBAL_SOCKET_IRQ_CONTROL_OFS);
	assign wr_hit = hit & reg_wr;
	assign ctrl_view = {3'h0, card_mode_reg, gr_reg} & cgic_pkg::CTRL_WMASK;
	assign level_sel = {gr_reg[cgic_pkg::STATUS_LEVEL_BIT],
		card_mode_reg[1], card_mode_reg[0]};
	assign global_reset_in_q = global_reset_in;
	assign bus_reset_in_q = bus_reset_in;

	// card mode bits: cleared by either reset
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			card_mode_reg <= 2'h0;
		end else if (global_reset_in_q | bus_reset_in_q) begin
			card_mode_reg <= 2'h0;
		end else if (wr_hit) begin
			card_mode_reg <= reg_wdata[cgic_pkg::SECOND_LEVEL_BIT:
				cgic_pkg::FIRST_LEVEL_BIT];
		end
	end

	// clear mode, status level, sleep: global reset only
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			gr_reg <= 3'h0;
		end else if (global_reset_in_q) begin
			// bus reset does not touch these
			gr_reg <= 3'h0;
		end else if (wr_hit) begin
			gr_reg <= reg_wdata[cgic_pkg::CLEAR_WRITE_BIT:0];
		end
	end

	// registered read data
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			rdata_reg <= 8'h00;
		end else if (hit & reg_rd) begin
			rdata_reg <= ctrl_view;
		end else begin
			rdata_reg <= 8'h00;
		end
	end

	// three-stage sync of external interrupt levels
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			src_s1 <= 3'h0;
			src_s2 <= 3'h0;
			src_s3 <= 3'h0;
			src_last <= 3'h0;
		end else begin
			src_s1 <= {status_irq_in, card_irq_in};
			src_s2 <= src_s1;
			src_s3 <= src_s2;
			src_last <= src_seen;
		end
	end
	// a change counts once stages two and three agree
	assign src_seen = (src_s2 & src_s3) | (src_last & (src_s2 | src_s3));
	assign src_rise = src_seen & ~src_last;

	// per source: level follows, edge pulses once
	// interrupts flow regardless of sleep
	genvar gi;
	generate
		for (gi = 0; gi < cgic_pkg::IRQ_SRC; gi++) begin : g_irq
			// one pulse per rise in edge mode
			assign irq_next[gi] = level_sel[gi] ? src_seen[gi] :
				src_rise[gi];
		end
	endgenerate

	// registered host interrupt lines
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			irq_reg <= 3'h0;
		end else begin
			irq_reg <= irq_next;
		end
	end

	// sleep: float outputs except while a card cycle runs
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			float_reg <= 1'b0;
		end else begin
			float_reg <= gr_reg[cgic_pkg::SLEEP_BIT] & ~card_cycle_active;
		end
	end

	// clear mode outputs and soft trigger clear
	always_ff @(posedge mclk or posedge rst) begin
		if (rst) begin
			cor_reg <= 1'b1;
			swclr_reg <= 1'b0;
		end else begin
			// clear-on-read when bit 2 is zero
			cor_reg <= ~gr_reg[cgic_pkg::CLEAR_WRITE_BIT];
			// write-one clear also drops soft trigger
			swclr_reg <= gr_reg[cgic_pkg::CLEAR_WRITE_BIT] &
				cd_flag_write_one;
		end
	end

	assign reg_rdata = rdata_reg;
	assign host_irq = irq_reg;
	assign card_outputs_float = float_reg;
	assign status_clear_on_read = cor_reg;
	assign soft_card_detect_clear = swclr_reg;

	// checks
	sequence wr_sleep_s;
		wr_hit && reg_wdata[0] && !global_reset_in_q;
	endsequence
	rsv_zero_a: assert property (@(posedge mclk) disable iff (rst)
		rdata_reg[7:5] == 3'h0) else $error("reserved bits not zero");
	global_reset_in_clr_a: assert property (@(posedge mclk) disable iff (rst)
		global_reset_in_q |=> gr_reg == 3'h0) else $error("global reset missed");
	bus_reset_in_keep_a: assert property (@(posedge mclk) disable iff (rst)
		bus_reset_in_q && !global_reset_in_q && !wr_hit |=> $stable(gr_reg))
		else $error("bus reset hit kept bits");
	sleep_float_a: assert property (@(posedge mclk) disable iff (rst)
		wr_sleep_s ##1 (!global_reset_in_q && !wr_hit && !card_cycle_active)
		|=> float_reg) else $error("sleep did not float");
	card_wake_a: assert property (@(posedge mclk) disable iff (rst)
		card_cycle_active |=> !float_reg) else $error("active cycle floated");
	edge_one_a: assert property (@(posedge mclk) disable iff (rst)
		!level_sel[0] && irq_reg[0] |=> !irq_reg[0])
		else $error("edge irq held");
	irq_level_a: assert property (@(posedge mclk) disable iff (rst)
		level_sel[2] |=> irq_reg[2] == $past(src_seen[2]))
		else $error("status level irq wrong");
	soft_clear_a: assert property (@(posedge mclk) disable iff (rst)
		cd_flag_write_one && gr_reg[2] |=> soft_card_detect_clear)
		else $error("soft trigger not cleared");
	clear_mode_a: assert property (@(posedge mclk) disable iff (rst)
		!gr_reg[2] |=> status_clear_on_read) else $error("clear mode wrong");

	// steady status input over three samples
	sequence status_high_s;
		status_irq_in [*3];
	endsequence
	sequence status_low_s;
		(!status_irq_in) [*3];
	endsequence
	// a card cycle has just ended while asleep
	sequence cycle_end_s;
		card_cycle_active ##1
			(!card_cycle_active && gr_reg[cgic_pkg::SLEEP_BIT]);
	endsequence

	// only its own writes or a global or bus reset change it
	miss_write_a: assert property (@(posedge mclk) disable iff (rst)
		!wr_hit && !global_reset_in_q && !bus_reset_in_q |=> $stable(ctrl_view))
		else $error("control bits changed without a write");

	rd_data_a: assert property (@(posedge mclk) disable iff (rst)
		hit && reg_rd |=> rdata_reg == $past(ctrl_view))
		else $error("read data wrong");

	rd_idle_a: assert property (@(posedge mclk) disable iff (rst)
		!(hit && reg_rd) |=> rdata_reg == 8'h00)
		else $error("read data not idle");

	second_wr_a: assert property (@(posedge mclk) disable iff (rst)
		wr_hit && !global_reset_in_q && !bus_reset_in_q |=>
		card_mode_reg[1] == $past(reg_wdata[cgic_pkg::SECOND_LEVEL_BIT]))
		else $error("second card mode not written");

	first_wr_a: assert property (@(posedge mclk) disable iff (rst)
		wr_hit && !global_reset_in_q && !bus_reset_in_q |=>
		card_mode_reg[0] == $past(reg_wdata[cgic_pkg::FIRST_LEVEL_BIT]))
		else $error("first card mode not written");

	low_wr_a: assert property (@(posedge mclk) disable iff (rst)
		wr_hit && !global_reset_in_q |=> gr_reg == $past(reg_wdata[2:0]))
		else $error("low control bits not written");

	write_clr_a: assert property (@(posedge mclk) disable iff (rst)
		gr_reg[cgic_pkg::CLEAR_WRITE_BIT] |=> !status_clear_on_read)
		else $error("clear-on-read kept in write mode");

	// status edge pulse is one cycle
	stat_edge_a: assert property (@(posedge mclk) disable iff (rst)
		!level_sel[2] && irq_reg[2] |=> !irq_reg[2])
		else $error("status edge irq held");

	float_off_a: assert property (@(posedge mclk) disable iff (rst)
		!gr_reg[cgic_pkg::SLEEP_BIT] |=> !float_reg)
		else $error("outputs floated while awake");

	// outputs float again after a cycle
	end_float_a: assert property (@(posedge mclk) disable iff (rst)
		cycle_end_s |=> float_reg)
		else $error("outputs not floated after cycle");

	// interrupts never wake the card side
	sleep_hold_a: assert property (@(posedge mclk) disable iff (rst)
		gr_reg[cgic_pkg::SLEEP_BIT] && !card_cycle_active |=> float_reg)
		else $error("woke without a card cycle");

	// steady input is seen after sync
	sync_high_a: assert property (@(posedge mclk) disable iff (rst)
		status_high_s |=> src_seen[2])
		else $error("status input not seen high");

	// steady low input is seen low
	sync_low_a: assert property (@(posedge mclk) disable iff (rst)
		status_low_s |=> !src_seen[2])
		else $error("status input not seen low");

	// stages disagreeing hold the last value
	sync_hold_a: assert property (@(posedge mclk) disable iff (rst)
		src_s2[2] != src_s3[2] |-> src_seen[2] == src_last[2])
		else $error("sync changed before agreement");

	// bus reset clears the card mode bits
	bus_clr_a: assert property (@(posedge mclk) disable iff (rst)
		bus_reset_in_q |=> card_mode_reg == 2'h0)
		else $error("bus reset kept card modes");

	// no soft clear without its cause
	soft_idle_a: assert property (@(posedge mclk) disable iff (rst)
		!(cd_flag_write_one && gr_reg[cgic_pkg::CLEAR_WRITE_BIT]) |=>
		!soft_card_detect_clear)
		else $error("soft trigger cleared without cause");

	first_lvl_a: assert property (@(posedge mclk) disable iff (rst)
		level_sel[0] |=> irq_reg[0] == $past(src_seen[0]))
		else $error("first card level irq wrong");

	second_lvl_a: assert property (@(posedge mclk) disable iff (rst)
		level_sel[1] |=> irq_reg[1] == $past(src_seen[1]))
		else $error("second card level irq wrong");

	// one pulse per rise, none otherwise
	generate
		for (gi = 0; gi < cgic_pkg::IRQ_SRC; gi++) begin : g_edge_chk
			edge_rise_a: assert property (
				@(posedge mclk) disable iff (rst)
				!level_sel[gi] && src_rise[gi] |=> irq_reg[gi])
				else $error("edge irq missed a rise");
			edge_low_a: assert property (
				@(posedge mclk) disable iff (rst)
				!level_sel[gi] && !src_rise[gi] |=> !irq_reg[gi])
				else $error("edge irq without a rise");
		end
	endgenerate
endmodule : cgic_ctrl
`default_nettype wire

// ### cgic_host.sv
// host-side model that reaches the control register
`timescale 1ns/1ps
`default_nettype none
module cgic_host (
	input wire logic mclk,
	output logic [11:0] reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata
);
	initial begin
		reg_addr = 12'h000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = 8'h00;
	end
	// one-cycle write strobe, data scrambled after
	task automatic wr(input logic [11:0] a, input logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(negedge mclk);
		reg_wr = 1'b0;
		reg_wdata = ~d;
	endtask : wr
	// read strobe, data taken the cycle after
	task automatic rd(input logic [11:0] a, output logic [7:0] d);
		@(negedge mclk);
		reg_addr = a;
		reg_rd = 1'b1;
		@(negedge mclk);
		reg_rd = 1'b0;
		d = reg_rdata;
	endtask : rd
endmodule : cgic_host
`default_nettype wire

// ### cgic_pkg.sv
// constants for the shared socket interrupt control register
package cgic_pkg;
	// register offset from the socket base address
	localparam logic [11:0] GLOBAL_SOCKET_IRQ_CONTROL_OFS = 12'h81E;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	// field positions
	localparam int SLEEP_BIT = 0;
	localparam int STATUS_LEVEL_BIT = 1;
	localparam int CLEAR_WRITE_BIT = 2;
	localparam int FIRST_LEVEL_BIT = 3;
	localparam int SECOND_LEVEL_BIT = 4;
	// writable field mask, bits 7..5 reserved
	localparam logic [7:0] CTRL_WMASK = 8'h1F;
	// number of interrupt sources: first card, second card, status change
	localparam int IRQ_SRC = 3;
	// card-detect change flag position in the status change flags
	localparam int CD_FLAG_BIT = 3;
endpackage : cgic_pkg

// ### tb.sv
// self-checking bench for the socket irq control register
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [11:0] A = cgic_pkg::GLOBAL_SOCKET_IRQ_CONTROL_OFS;
	logic mclk, rst, global_reset_in, bus_reset_in, card_cycle_active;
	logic cd_flag_write_one, reg_wr, reg_rd, clr_rd, soft_clr, flt;
	logic [11:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, rv;
	logic [2:0] src, host_irq;
	int err_count = 0, samples_checked = 0, cyc = 0, n;
	cgic_host HOST (.mclk(mclk), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
	cgic_ctrl DUT (.mclk(mclk), .rst(rst), .global_reset_in(global_reset_in),
		.bus_reset_in(bus_reset_in), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
		.card_irq_in(src[1:0]), .status_irq_in(src[2]),
		.card_cycle_active(card_cycle_active),
		.cd_flag_write_one(cd_flag_write_one), .status_clear_on_read(clr_rd),
		.soft_card_detect_clear(soft_clr), .card_outputs_float(flt),
		.host_irq(host_irq));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	// cycle ceiling against hangs
	always @(posedge mclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_count++;
			finish_test();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] %0t got %h want %h", $time, got, exp);
		end
	endtask : chk
	task automatic finish_test();
		$display("errors %0d checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : finish_test
	task automatic t_regs();
		HOST.rd(A, rv);
		chk(rv, cgic_pkg::CTRL_RESET);
		HOST.wr(A, 8'hFF);
		HOST.rd(A, rv);
		chk(rv, 8'h1F);
		HOST.rd(12'h81F, rv);
		chk(rv, 8'h00);
	endtask : t_regs
	task automatic t_resets();
		@(negedge mclk) bus_reset_in = 1'b1;
		@(negedge mclk) bus_reset_in = 1'b0;
		HOST.rd(A, rv);
		chk(rv, 8'h07);
		@(negedge mclk) global_reset_in = 1'b1;
		@(negedge mclk) global_reset_in = 1'b0;
		HOST.rd(A, rv);
		chk(rv, 8'h00);
	endtask : t_resets
	// one write-one pulse, then count soft clear pulses
	task automatic cd_pulse(output int cnt);
		cnt = 0;
		@(negedge mclk) cd_flag_write_one = 1'b1;
		repeat (5) @(negedge mclk) begin
			cd_flag_write_one = 1'b0;
			if (soft_clr === 1'b1) cnt++;
		end
	endtask : cd_pulse
	task automatic t_clear();
		chk({7'h00, clr_rd}, 8'h01);
		cd_pulse(n);
		chk(8'(n), 8'h00);
		HOST.wr(A, 8'h04);
		repeat (2) @(negedge mclk);
		chk({7'h00, clr_rd}, 8'h00);
		cd_pulse(n);
		chk(8'(n), 8'h01);
	endtask : t_clear
	task automatic t_sleep();
		HOST.wr(A, 8'h01);
		repeat (2) @(negedge mclk);
		chk({7'h00, flt}, 8'h01);
		card_cycle_active = 1'b1;
		repeat (2) @(negedge mclk);
		chk({7'h00, flt}, 8'h00);
		card_cycle_active = 1'b0;
		repeat (3) @(negedge mclk);
		chk({7'h00, flt}, 8'h01);
	endtask : t_sleep
	task automatic t_irq();
		int lv[3] = '{cgic_pkg::FIRST_LEVEL_BIT, cgic_pkg::SECOND_LEVEL_BIT,
			cgic_pkg::STATUS_LEVEL_BIT};
		for (int i = 0; i < 3; i++) begin
			// edge first, then level, sleep kept on
			HOST.wr(A, 8'h01);
			n = 0;
			src[i] = 1'b1;
			repeat (12) @(negedge mclk) if (host_irq[i] === 1'b1) n++;
			chk(8'(n), 8'h01);
			src[i] = 1'b0;
			HOST.wr(A, 8'h01 | (8'h01 << lv[i]));
			src[i] = 1'b1;
			repeat (10) @(negedge mclk);
			chk({7'h00, host_irq[i]}, 8'h01);
			chk({7'h00, flt}, 8'h01);
			src[i] = 1'b0;
			repeat (8) @(negedge mclk);
		end
	endtask : t_irq
	initial begin
		rst = 1'b1;
		{global_reset_in, bus_reset_in, card_cycle_active} = 3'h0;
		cd_flag_write_one = 1'b0;
		src = 3'h0;
		repeat (2) @(negedge mclk);
		rst = 1'b0;
		t_regs();
		t_resets();
		t_clear();
		t_sleep();
		t_irq();
		finish_test();
	end
endmodule : tb
`default_nettype wire
